/* File: shared/op_mode_map.svh */
// Purpose: constants for the operation mode selector
// Assumes: settings arrive as small unsigned codes
// Notes: definitions only
`ifndef OP_MODE_MAP_SVH
`define OP_MODE_MAP_SVH
// =====================================
// mode select setting codes
`define MSEL_W 4
`define MSEL_SWITCH 4'h0
`define MSEL_PANEL 4'h1
`define MSEL_EXT 4'h2
`define MSEL_COMB_A 4'h3
`define MSEL_COMB_B 4'h4
`define MSEL_RUNSW 4'h6
`define MSEL_INTERLOCK 4'h7
// =====================================
// communication startup codes
`define CSTART_W 5
`define CSTART_0 5'h00
`define CSTART_1 5'h01
`define CSTART_2 5'h02
`define CSTART_10 5'h0a
`define CSTART_12 5'h0c
// =====================================
// terminal function codes
`define FUNC_W 8
`define FUNC_PANEL_EXT 8'h10
`define FUNC_INTERLOCK 8'h0c
`define FUNC_PANEL_NET 8'h41
`define FUNC_EXT_NET 8'h42
// =====================================
// command source setting
`define NSRC_W 2
`define NSRC_OPTION 2'h0
`endif

/* File: shared/op_mode_pkg.sv */
// Purpose: types for the operation mode selector
// Assumes: nothing
// Notes: mode encoding shown on op_mode output
package op_mode_pkg;
    typedef enum logic [1:0] {
        MODE_EXT = 2'b00,
        MODE_PANEL = 2'b01,
        MODE_NET = 2'b10,
        MODE_COMB = 2'b11
    } op_mode_t;
endpackage

/* File: src/operation_mode_selector.sv */
// Purpose: picks panel, external, network or combined control
// Assumes: terminal pins are asynchronous; settings are static on core_clk
// Notes: one cycle of mode latency after the second sync stage
//
// Operation
// - panel/external change only while stopped, 6 running
// - panel/external switch valid for selection 0,6,7
// - terminal codes 16, 65, 66 assign switches
// - selection 0/6: switch on external, off panel
// - selection 2 fixed external, network still allowed
// - selection 1 panel; 3/4 combined, fixed
// - selection 7 interlock off forces external
// - selection 7 interlock on: normal, output stop
// - precedence setting, interlock, ext/net, panel/net, panel/ext
// - network switches act only stopped, 6 running
// - panel/net needs selection 0/6, startup 10/12
// - panel/net on panel, off network
// - panel request plus ext/net gives network
// - network request falls to panel in cases
// - startup 10/12 with 0/6 refuses external
// - startup 10/12 with selection 2 network fixed
// - startup 10/12, 7, interlock: ext/panel by switch
// - ext/net needs 0,2,6,7 and startup 0-2
// - ext/net on network, off external
// - network request without option gives panel, external in 2
// - external request: panel/ext or panel/net decides
// - selection 2 refuses change into panel
// - no interlock terminal: output stop input used
`timescale 1ns/1ps
`include "op_mode_map.svh"

module operation_mode_selector #(
    parameter int N_TERM = 12
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // settings
    input wire logic [`MSEL_W-1:0] mode_select_setting,
    input wire logic [`CSTART_W-1:0] comm_startup_setting,
    input wire logic [`NSRC_W-1:0] net_command_source_setting,
    input wire logic comm_option_fitted,
    input wire logic [N_TERM*`FUNC_W-1:0] input_terminal_function_selectors,
    // pins
    input wire logic [N_TERM-1:0] term_pins,
    input wire logic output_stop_input,
    input wire logic forward_run_command,
    input wire logic reverse_run_command,
    input wire logic motor_running,
    // status
    output op_mode_pkg::op_mode_t op_mode,
    output logic output_stop
);
    // =====================================
    // pin synchronisers
    logic [N_TERM+3:0] sync1;
    logic [N_TERM+3:0] sync2;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {motor_running, reverse_run_command, forward_run_command, output_stop_input, term_pins};
            sync2 <= sync1;
        end
    end
    wire logic [N_TERM-1:0] pins_s = sync2[N_TERM-1:0];
    wire logic mrs_s = sync2[N_TERM];
    wire logic stopped = !sync2[N_TERM+1] && !sync2[N_TERM+2] && !sync2[N_TERM+3];

    // =====================================
    // terminal function decode
    function automatic logic [1:0] find_func(input logic [N_TERM*`FUNC_W-1:0] sel,
            input logic [N_TERM-1:0] pins, input logic [`FUNC_W-1:0] code);
        logic [1:0] r;
        r = 2'b00;
        for (int i = 0; i < N_TERM; i++) begin
            if (sel[i*`FUNC_W +: `FUNC_W] == code) begin
                r = {1'b1, r[0] | pins[i]};
            end
        end
        return r;
    endfunction

    wire logic [1:0] f_pe = find_func(input_terminal_function_selectors, pins_s, `FUNC_PANEL_EXT);
    wire logic [1:0] f_pn = find_func(input_terminal_function_selectors, pins_s, `FUNC_PANEL_NET);
    wire logic [1:0] f_en = find_func(input_terminal_function_selectors, pins_s, `FUNC_EXT_NET);
    wire logic [1:0] f_il = find_func(input_terminal_function_selectors, pins_s, `FUNC_INTERLOCK);
    // unassigned panel/ext reads as off, i.e. panel
    wire logic pe_on = f_pe[1] && f_pe[0];
    wire logic pn_on = f_pn[1] && f_pn[0];
    wire logic en_on = f_en[1] && f_en[0];
    wire logic interlock = f_il[1] ? f_il[0] : mrs_s;

    // =====================================
    // setting decode
    wire logic [`MSEL_W-1:0] ms = mode_select_setting;
    wire logic ms_sw = (ms == `MSEL_SWITCH);
    wire logic ms_run = (ms == `MSEL_RUNSW);
    wire logic ms_ext = (ms == `MSEL_EXT);
    wire logic ms_il = (ms == `MSEL_INTERLOCK);
    wire logic cs_pn = (comm_startup_setting == `CSTART_10) || (comm_startup_setting == `CSTART_12);
    wire logic cs_en = (comm_startup_setting == `CSTART_0) || (comm_startup_setting == `CSTART_1)
        || (comm_startup_setting == `CSTART_2);
    wire logic no_net = (net_command_source_setting == `NSRC_OPTION) && !comm_option_fitted;
    // selection 6 allows change while running
    wire logic may_change = stopped || ms_run;
    wire logic il_ok = !ms_il || interlock;

    // panel/external level
    wire logic pe_mode_ext = pe_on;
    // panel/network path
    wire logic pn_active = cs_pn && f_pn[1] && (ms_sw || ms_run);
    wire logic pn_net_req = !pn_on;
    wire logic pn_go_panel = no_net || !pe_on;
    // external/network path
    wire logic en_active = cs_en && f_en[1] && (ms_sw || ms_run || ms_ext || ms_il) && il_ok;

    // =====================================
    // mode resolution, in precedence order
    op_mode_pkg::op_mode_t target;
    always_comb begin
        target = op_mode;
        if (ms == `MSEL_PANEL) begin
            target = op_mode_pkg::MODE_PANEL;
        end else if (ms == `MSEL_COMB_A || ms == `MSEL_COMB_B) begin
            target = op_mode_pkg::MODE_COMB;
        end else if (ms_il && !interlock) begin
            target = op_mode_pkg::MODE_EXT;
        end else if (ms_ext && cs_pn) begin
            target = op_mode_pkg::MODE_NET;
        end else if (en_active) begin
            if (en_on) begin
                // selection 2 never falls back to panel, even without the option
                if (no_net && ms_ext) begin
                    target = op_mode_pkg::MODE_EXT;
                end else begin
                    target = no_net ? op_mode_pkg::MODE_PANEL : op_mode_pkg::MODE_NET;
                end
            end else if (ms_ext) begin
                target = op_mode_pkg::MODE_EXT;
            end else if (f_pn[1]) begin
                target = pn_on ? op_mode_pkg::MODE_PANEL : op_mode_pkg::MODE_NET;
            end else begin
                target = pe_on ? op_mode_pkg::MODE_EXT : op_mode_pkg::MODE_PANEL;
            end
        end else if (pn_active) begin
            if (!pn_net_req) begin
                target = en_on ? op_mode_pkg::MODE_NET : op_mode_pkg::MODE_PANEL;
            end else begin
                target = pn_go_panel ? op_mode_pkg::MODE_PANEL : op_mode_pkg::MODE_NET;
            end
        end else if (cs_pn && (ms_sw || ms_run)) begin
            // external refused here; keep network or panel
            if (op_mode == op_mode_pkg::MODE_EXT) begin
                target = op_mode_pkg::MODE_NET;
            end
        end else if (ms_ext) begin
            if (op_mode != op_mode_pkg::MODE_NET) begin
                target = op_mode_pkg::MODE_EXT;
            end
        end else if (ms_sw || ms_run || ms_il) begin
            target = pe_mode_ext ? op_mode_pkg::MODE_EXT : op_mode_pkg::MODE_PANEL;
        end
    end

    // fixed settings and forced external act at once; switches wait for stop except in selection 6
    wire logic forced = (ms == `MSEL_PANEL) || (ms == `MSEL_COMB_A) || (ms == `MSEL_COMB_B)
        || (ms_il && !interlock) || (ms_ext && cs_pn);
    wire op_mode_pkg::op_mode_t next_op_mode = (forced || may_change) ? target : op_mode;
    wire logic next_output_stop = ms_il && interlock && (next_op_mode == op_mode_pkg::MODE_EXT)
        && mrs_s && !f_il[1];

    // =====================================
    // state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_mode <= op_mode_pkg::MODE_EXT;
            output_stop <= 1'b0;
        end else begin
            op_mode <= next_op_mode;
            output_stop <= next_output_stop;
        end
    end
endmodule // operation_mode_selector

/* File: dv/term_panel_model.sv */
// Purpose: terminals and panel levers facing the selector
// Assumes: four terminals, terminal 3 unassigned; network switches may be unassigned
// Notes: lever bits are run, lock, ext/net, panel/net, panel/ext
`timescale 1ns/1ps
`include "op_mode_map.svh"
// ====================
// terminal wiring
module term_panel_model (
    // levers
    input wire logic [4:0] lv,
    input wire logic net_switches_fitted,
    // terminal side
    output logic [3:0] term_pins,
    output logic [31:0] input_terminal_function_selectors,
    output logic output_stop_input,
    output logic forward_run_command,
    output logic reverse_run_command,
    output logic motor_running
);
    // no terminal carries the interlock code, so the stop input doubles as interlock
    // without the network codes the panel/external switch alone decides
    assign input_terminal_function_selectors = {8'h00, net_switches_fitted ? `FUNC_EXT_NET : 8'h00,
        net_switches_fitted ? `FUNC_PANEL_NET : 8'h00, `FUNC_PANEL_EXT};
    assign term_pins = {1'b0, lv[2:0]};
    assign output_stop_input = lv[3];
    assign forward_run_command = lv[4];
    assign reverse_run_command = 1'b0;
    assign motor_running = lv[4];
endmodule // term_panel_model

/* File: dv/op_mode_checker.sv */
// Purpose: port assertions for the mode selector
// Assumes: settings static between steps
// Notes: settings reach op_mode one edge later
`timescale 1ns/1ps
`include "op_mode_map.svh"
// ====================
// checker
module op_mode_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // inputs watched
    input wire logic [`MSEL_W-1:0] mode_select_setting,
    input wire logic [`CSTART_W-1:0] comm_startup_setting,
    input wire logic output_stop_input,
    input wire logic motor_running,
    // status
    input wire op_mode_pkg::op_mode_t op_mode,
    input wire logic output_stop
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_fixed_panel:
    assert property (mode_select_setting == 4'h1 |=> op_mode == op_mode_pkg::MODE_PANEL) else $error("panel lost");
    chk_fixed_comb:
    assert property (mode_select_setting inside {4'h3, 4'h4} |=> op_mode == op_mode_pkg::MODE_COMB) else $error("comb lost");
    chk_ext_no_panel:
    assert property (mode_select_setting == 4'h2 |=> op_mode != op_mode_pkg::MODE_PANEL) else $error("panel in 2");
    chk_net_fixed:
    assert property (mode_select_setting == 4'h2 && comm_startup_setting inside {5'h0a, 5'h0c}
        |=> op_mode == op_mode_pkg::MODE_NET) else $error("net lost");
    chk_no_ext_entry:
    assert property (mode_select_setting inside {4'h0, 4'h6} && comm_startup_setting inside {5'h0a, 5'h0c}
        && op_mode != op_mode_pkg::MODE_EXT |=> op_mode != op_mode_pkg::MODE_EXT) else $error("ext entered");
    chk_run_hold:
    assert property (($stable(comm_startup_setting) && mode_select_setting == 4'h0 && motor_running)[*4]
        |=> $stable(op_mode)) else $error("changed running");
    chk_stop_flag:
    assert property (output_stop |-> op_mode == op_mode_pkg::MODE_EXT && $past(mode_select_setting) == 4'h7)
        else $error("stray stop");
    chk_lock_forced:
    assert property ((mode_select_setting == 4'h7 && !output_stop_input)[*4] |=> op_mode == op_mode_pkg::MODE_EXT)
        else $error("not forced");
    cover property (op_mode == op_mode_pkg::MODE_NET);
    cover property (output_stop);
    cover property (op_mode == op_mode_pkg::MODE_PANEL ##1 op_mode == op_mode_pkg::MODE_EXT);
endmodule // op_mode_checker
bind operation_mode_selector op_mode_checker u_op_mode_checker (.core_clk, .rst_n, .mode_select_setting,
    .comm_startup_setting, .output_stop_input, .motor_running, .op_mode, .output_stop);

/* File: dv/tb.sv */
// Purpose: self-checking bench for the mode selector
// Assumes: 10 MHz core_clk, inputs move on the falling edge
// Notes: pins need three edges, so each step waits five
`timescale 1ns/1ps
// ====================
// bench
module tb;
    localparam logic [1:0] ext = op_mode_pkg::MODE_EXT;
    localparam logic [1:0] pan = op_mode_pkg::MODE_PANEL;
    localparam logic [1:0] net = op_mode_pkg::MODE_NET;
    localparam logic [1:0] comb = op_mode_pkg::MODE_COMB;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] msel = 4'h0;
    logic [4:0] cst = 5'h00;
    logic [1:0] nsrc = 2'h1;
    logic opt = 1'b1;
    logic [4:0] lv = 5'h00;
    logic net_sw = 1'b1;
    logic [3:0] term_pins;
    logic [31:0] input_terminal_function_selectors;
    logic output_stop_input, forward_run_command, reverse_run_command, motor_running, output_stop;
    op_mode_pkg::op_mode_t op_mode;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    initial forever #50 core_clk = ~core_clk;
    term_panel_model u_term_panel_model (.lv(lv), .net_switches_fitted(net_sw), .term_pins,
        .input_terminal_function_selectors,
        .output_stop_input, .forward_run_command, .reverse_run_command, .motor_running);
    operation_mode_selector #(.N_TERM(4)) u_operation_mode_selector (.core_clk, .rst_n, .mode_select_setting(msel),
        .comm_startup_setting(cst), .net_command_source_setting(nsrc), .comm_option_fitted(opt),
        .input_terminal_function_selectors, .term_pins, .output_stop_input, .forward_run_command,
        .reverse_run_command, .motor_running, .op_mode, .output_stop);
    task automatic chk(input logic [1:0] seen, input logic [1:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input logic [3:0] m, input logic [4:0] c, input logic [4:0] l, input logic [1:0] e);
        @(negedge core_clk);
        msel = m;
        cst = c;
        lv = l;
        repeat (5) @(negedge core_clk);
        chk(op_mode, e, "op_mode");
    endtask
    task automatic t_fixed();
        step(4'h1, 5'h00, 5'h01, pan);
        step(4'h3, 5'h00, 5'h05, comb);
        step(4'h4, 5'h0a, 5'h03, comb);
        step(4'h1, 5'h00, 5'h10, pan);
    endtask
    task automatic t_panel_ext();
        net_sw = 1'b0;
        step(4'h0, 5'h00, 5'h01, ext);
        step(4'h0, 5'h00, 5'h00, pan);
        step(4'h0, 5'h00, 5'h10, pan);
        step(4'h0, 5'h00, 5'h11, pan);
        step(4'h6, 5'h00, 5'h11, ext);
        step(4'h6, 5'h00, 5'h01, ext);
        net_sw = 1'b1;
    endtask
    task automatic t_ext_net();
        step(4'h0, 5'h00, 5'h05, net);
        opt = 1'b0;
        nsrc = 2'h0;
        step(4'h0, 5'h00, 5'h05, pan);
        opt = 1'b1;
        nsrc = 2'h1;
        step(4'h6, 5'h00, 5'h15, net);
        step(4'h2, 5'h00, 5'h00, ext);
        step(4'h2, 5'h00, 5'h04, net);
        opt = 1'b0;
        nsrc = 2'h0;
        step(4'h2, 5'h00, 5'h04, ext);
        opt = 1'b1;
        nsrc = 2'h1;
        step(4'h2, 5'h0a, 5'h00, net);
    endtask
    task automatic t_panel_net();
        step(4'h0, 5'h0a, 5'h03, pan);
        step(4'h0, 5'h0a, 5'h01, net);
        step(4'h0, 5'h0a, 5'h00, pan);
        step(4'h0, 5'h0a, 5'h06, net);
    endtask
    task automatic t_lock();
        net_sw = 1'b0;
        step(4'h7, 5'h00, 5'h07, ext);
        step(4'h7, 5'h00, 5'h08, pan);
        step(4'h7, 5'h00, 5'h09, ext);
        chk({1'b0, output_stop}, 2'h1, "output_stop");
        net_sw = 1'b1;
        step(4'h7, 5'h00, 5'h0d, net);
        step(4'h7, 5'h0a, 5'h09, ext);
    endtask
    task automatic wrap_up();
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard: whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        t_fixed();
        t_panel_ext();
        t_ext_net();
        t_panel_net();
        t_lock();
        wrap_up();
    end
endmodule // tb
